// ---- hw/gpio_occ_port.v ----
// general-purpose pin port with timed levels plus occupancy sensor input
//
// Behaviour
// - per-pin direction register, input or output
// - driven level of each pin reads back
// - level write drives and holds pin level
// - timed level for 1 to 120 seconds
// - toggle inverts driven level of pin
// - raw occupancy pin level is readable
// - polarity selects which level means occupied
// - polarity resets to active high
// - occupied when level matches polarity, else free
`timescale 1ns/1ps
`default_nettype none
`include "gpio_occ_regs.vh"

module gpio_occ_port #(
  parameter NUM_PINS      = 4,
  parameter SECOND_CYCLES = `SECOND_CYCLES,
  parameter SUB_W         = 28
) (
  input  wire                CLK_SYS_I,
  input  wire                RST_N_I,
  input  wire [`ADDR_W-1:0]  ADDR_I,
  input  wire [`DATA_W-1:0]  WDATA_I,
  input  wire                WR_I,
  input  wire                RD_I,
  output reg  [`DATA_W-1:0]  RDATA_O,
  input  wire [NUM_PINS-1:0] GPIO_I,
  output reg  [NUM_PINS-1:0] GPIO_O,
  output reg  [NUM_PINS-1:0] GPIO_OE_O,
  input  wire                OCC_I,
  output reg                 OCCUPIED_O
);

  // shared constants are wider than this port, cut on purpose
  localparam [31:0]      RELOAD_FULL = SECOND_CYCLES - 1;
  localparam [SUB_W-1:0] SUB_RELOAD  = RELOAD_FULL[SUB_W-1:0];
  localparam [15:0]      DIR_RST_W   = `RST_DIRECTION;
  localparam [15:0]      LEVEL_RST_W = `RST_LEVEL;

  reg  [NUM_PINS-1:0] busy_q;
  reg                 occupancy_polarity_q;
  wire [NUM_PINS-1:0] pin_level;
  wire                occ_level;

  wire wr_dir   = WR_I && (ADDR_I == `OFF_DIRECTION);
  wire wr_level = WR_I && (ADDR_I == `OFF_LEVEL);
  wire wr_tog   = WR_I && (ADDR_I == `OFF_TOGGLE);
  wire wr_ivl   = WR_I && (ADDR_I == `OFF_INTERVAL);
  wire wr_occ   = WR_I && (ADDR_I == `OFF_OCC_CTRL);

  wire [6:0] ivl_secs  = WDATA_I[`IVL_SECS_MSB:`IVL_SECS_LSB];
  wire       ivl_level = WDATA_I[`IVL_LEVEL_BIT];
  wire [3:0] ivl_pin   = WDATA_I[`IVL_PIN_MSB:`IVL_PIN_LSB];
  // out-of-range durations are dropped rather than clamped
  wire       ivl_ok    = (ivl_secs >= `IVL_SECS_MIN) && (ivl_secs <= `IVL_SECS_MAX);

  pin_sync3 #(
    .WIDTH (NUM_PINS + 1)
  ) u_sync (
    .CLK_SYS_I (CLK_SYS_I),
    .RST_N_I   (RST_N_I),
    .PIN_I     ({OCC_I, GPIO_I}),
    .LEVEL_O   ({occ_level, pin_level})
  );

  // direction: 1 drives the pin
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      GPIO_OE_O <= DIR_RST_W[NUM_PINS-1:0];
    end else if (wr_dir) begin
      GPIO_OE_O <= WDATA_I[NUM_PINS-1:0];
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i = i + 1) begin : g_pin
      reg  [6:0]       secs_q;
      reg  [SUB_W-1:0] sub_q;
      wire             is_out  = GPIO_OE_O[i];
      wire             int_hit = wr_ivl && ivl_ok && (ivl_pin == i) && is_out;
      wire             set_hit = wr_level && is_out;
      wire             tog_hit = wr_tog && WDATA_I[i] && is_out;

      always @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
          GPIO_O[i] <= LEVEL_RST_W[i];
          busy_q[i] <= 1'b0;
          secs_q    <= 7'h00;
          sub_q     <= {SUB_W{1'b0}};
        end else if (!is_out) begin
          // switching to input abandons a running interval
          busy_q[i] <= 1'b0;
        end else if (int_hit) begin
          GPIO_O[i] <= ivl_level;
          busy_q[i] <= 1'b1;
          secs_q    <= ivl_secs;
          sub_q     <= SUB_RELOAD;
        end else if (set_hit) begin
          GPIO_O[i] <= WDATA_I[i];
          busy_q[i] <= 1'b0;
        end else if (tog_hit) begin
          GPIO_O[i] <= ~GPIO_O[i];
          busy_q[i] <= 1'b0;
        end else if (busy_q[i]) begin
          // per-pin sub-second count so every interval lasts whole seconds
          if (sub_q == {SUB_W{1'b0}}) begin
            sub_q <= SUB_RELOAD;
            if (secs_q == `IVL_SECS_MIN) begin
              busy_q[i] <= 1'b0;
              GPIO_O[i] <= ~GPIO_O[i];
            end else begin
              secs_q <= secs_q - 7'h01;
            end
          end else begin
            sub_q <= sub_q - {{(SUB_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  endgenerate

  // occupancy
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      occupancy_polarity_q <= `RST_OCC_POL;
      OCCUPIED_O           <= 1'b0;
    end else begin
      if (wr_occ) begin
        occupancy_polarity_q <= WDATA_I[`OCC_POL_BIT];
      end
      OCCUPIED_O <= ~(occ_level ^ occupancy_polarity_q);
    end
  end

  // read port: data valid only in the cycle after the strobe
  reg [`DATA_W-1:0] rd_d;
  always @* begin
    rd_d = {`DATA_W{1'b0}};
    case (ADDR_I)
      `OFF_DIRECTION:     rd_d[NUM_PINS-1:0] = GPIO_OE_O;
      `OFF_LEVEL:         rd_d[NUM_PINS-1:0] = GPIO_O;
      `OFF_OCC_CTRL:      rd_d[`OCC_POL_BIT] = occupancy_polarity_q;
      `OFF_OCC_STATUS: begin
        rd_d[`OCC_RAW_BIT]   = occ_level;
        rd_d[`OCC_STATE_BIT] = OCCUPIED_O;
      end
      `OFF_PIN_INPUT:     rd_d[NUM_PINS-1:0] = pin_level;
      `OFF_INTERVAL_BUSY: rd_d[NUM_PINS-1:0] = busy_q;
      default:            rd_d = {`DATA_W{1'b0}};
    endcase
  end

  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      RDATA_O <= {`DATA_W{1'b0}};
    end else if (RD_I) begin
      RDATA_O <= rd_d;
    end else begin
      RDATA_O <= {`DATA_W{1'b0}};
    end
  end

endmodule // gpio_occ_port

`default_nettype wire

// ---- hw/gpio_occ_regs.vh ----
// register map, field positions, reset values and timing for the pin port
`ifndef GPIO_OCC_REGS_VH
`define GPIO_OCC_REGS_VH

`define ADDR_W             8
`define DATA_W             32

`define OFF_DIRECTION      8'h00
`define OFF_LEVEL          8'h04
`define OFF_TOGGLE         8'h08
`define OFF_INTERVAL       8'h0C
`define OFF_OCC_CTRL       8'h10
`define OFF_OCC_STATUS     8'h14
`define OFF_PIN_INPUT      8'h18
`define OFF_INTERVAL_BUSY  8'h1C

`define IVL_SECS_LSB       0
`define IVL_SECS_MSB       6
`define IVL_LEVEL_BIT      7
`define IVL_PIN_LSB        8
`define IVL_PIN_MSB        11

`define OCC_POL_BIT        0
`define OCC_RAW_BIT        0
`define OCC_STATE_BIT      1

`define RST_DIRECTION      16'h0000
`define RST_LEVEL          16'h0000
`define RST_OCC_POL        1'b1

`define IVL_SECS_MIN       7'h01
`define IVL_SECS_MAX       7'h78

`define CLK_FREQ_HZ        200000000
`define ONE_SECOND_MS      1000
`define SECOND_CYCLES      (`ONE_SECOND_MS * (`CLK_FREQ_HZ / 1000))

`endif

// ---- hw/pin_sync3.v ----
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             CLK_SYS_I,
  input  wire             RST_N_I,
  input  wire [WIDTH-1:0] PIN_I,
  output reg  [WIDTH-1:0] LEVEL_O
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer         b;

  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      meta_q  <= {WIDTH{1'b0}};
      s2_q    <= {WIDTH{1'b0}};
      s3_q    <= {WIDTH{1'b0}};
      LEVEL_O <= {WIDTH{1'b0}};
    end else begin
      meta_q <= PIN_I;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      // a one-cycle glitch past stage one never reaches the output
      for (b = 0; b < WIDTH; b = b + 1) begin
        if (s2_q[b] == s3_q[b]) begin
          LEVEL_O[b] <= s3_q[b];
        end
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

// ---- test/gpio_and_occupancy_input_bench.sv ----
// self-checking bench for the pin port and occupancy input
`timescale 1ns/1ps
`default_nettype none
module gpio_and_occupancy_input_bench;
  logic clk, rst_n, wr, rd, occ, occd, lvl;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] gpio_i, gpio_o, oe, ext;
  int n_errors = 0, tests_run = 0;
  // one second shortened to ten cycles
  gpio_occ_port #(.SECOND_CYCLES(10)) i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GPIO_I(gpio_i), .GPIO_O(gpio_o), .GPIO_OE_O(oe), .OCC_I(occ),
    .OCCUPIED_O(occd));
  pin_side_model i_far (.gpio_o(gpio_o), .oe(oe), .ext(ext), .lvl(lvl), .gpio_i(gpio_i), .occ(occ));
  initial begin clk = 0; forever #2.5 clk = ~clk; end
  task cmp(input [31:0] g, e);
    tests_run++;
    if (g !== e) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, g, e); end
  endtask
  task wr32(input [7:0] a, input [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1; @(posedge clk); wr <= 0; #1;
  endtask
  task rd32(input [7:0] a, input [31:0] e);
    @(posedge clk); addr <= a; rd <= 1; @(posedge clk); rd <= 0; #1 cmp(rdata, e);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_reset;
    rd32(8'h00, 0);
    rd32(8'h10, 1);
    rd32(8'h40, 0);
  endtask
  task t_level;
    wr32(8'h00, 5); cmp(oe, 5);
    wr32(8'h04, 15); cmp(gpio_o, 5);
    rd32(8'h04, 5);
    repeat (4) @(posedge clk);
    rd32(8'h18, 7);
  endtask
  task t_toggle;
    wr32(8'h08, 15); cmp(gpio_o, 0);
    rd32(8'h04, 0);
  endtask
  task t_interval;
    wr32(8'h0C, 32'h0000_0081);
    // one second is ten cycles here: high for all ten, low right after
    repeat (10) begin cmp(gpio_o[0], 1); @(posedge clk); #1; end
    cmp(gpio_o, 0);
    // zero seconds, 121 seconds, an input pin
    wr32(8'h0C, 32'h0000_0080); cmp(gpio_o, 0);
    wr32(8'h0C, 32'h0000_00F9); cmp(gpio_o, 0);
    wr32(8'h0C, 32'h0000_0181); cmp(gpio_o, 0);
    // longest interval is taken, then cut short by a level write
    wr32(8'h0C, 32'h0000_02F8); cmp(gpio_o, 4);
    rd32(8'h1C, 4);
    wr32(8'h04, 0); cmp(gpio_o, 0);
    rd32(8'h1C, 0);
  endtask
  task t_occ;
    for (int p = 0; p < 2; p++) for (int v = 0; v < 2; v++) begin
      @(posedge clk); lvl <= v[0];
      wr32(8'h10, p);
      rd32(8'h10, p);
      repeat (10) @(posedge clk);
      #1 cmp(occd, v == p);
      rd32(8'h14, {v == p, v[0]});
    end
  endtask
  initial begin #20000; n_errors++; wrap_up; end
  initial begin
    rst_n = 0; wr = 0; rd = 0; addr = 0; wdata = 0; ext = 4'h2; lvl = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset; t_level; t_toggle; t_interval; t_occ;
    wrap_up;
  end
endmodule // gpio_and_occupancy_input_bench
`default_nettype wire

// ---- test/gpio_occ_props_properties.sv ----
// assertions for the pin port and occupancy input
`timescale 1ns/1ps
`default_nettype none
module gpio_occ_props #(parameter NUM_PINS = 4) (
  input wire logic                CLK_SYS_I,
  input wire logic                RST_N_I,
  input wire logic                WR_I,
  input wire logic                RD_I,
  input wire logic                OCC_I,
  input wire logic                OCCUPIED_O,
  input wire logic [7:0]          ADDR_I,
  input wire logic [31:0]         WDATA_I,
  input wire logic [31:0]         RDATA_O,
  input wire logic [NUM_PINS-1:0] GPIO_O,
  input wire logic [NUM_PINS-1:0] GPIO_OE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  logic pol_q;
  always_ff @(posedge CLK_SYS_I)
    pol_q <= !RST_N_I ? 1'b1 : (WR_I && ADDR_I == 8'h10) ? WDATA_I[0] : pol_q;
  // eight quiet cycles outlast the synchroniser
  sequence s_calm;
    (RST_N_I && $stable(OCC_I) && !(WR_I && ADDR_I == 8'h10))[*8];
  endsequence
  sequence s_ivl;
    WR_I && ADDR_I == 8'h0C && WDATA_I[11:0] == 12'h081 && GPIO_OE_O[0];
  endsequence
  // bench second is ten cycles: high for all ten, low on the eleventh
  sequence s_ivl_hold;
    GPIO_O[0] [*5] ##1 GPIO_O[0] [*5] ##1 !GPIO_O[0];
  endsequence
  a_dir_write:
    assert property (WR_I && ADDR_I == 8'h00 |=> GPIO_OE_O == $past(WDATA_I[NUM_PINS-1:0])) else $error("dir");
  a_dir_hold:
    assert property (!(WR_I && ADDR_I == 8'h00) |=> $stable(GPIO_OE_O)) else $error("dir hold");
  a_level_set:
    assert property (WR_I && ADDR_I == 8'h04 |=> GPIO_O == ($past(GPIO_OE_O) & $past(WDATA_I[NUM_PINS-1:0])
      | ~$past(GPIO_OE_O) & $past(GPIO_O))) else $error("level");
  a_toggle_inv:
    assert property (WR_I && ADDR_I == 8'h08 |=> GPIO_O == ($past(GPIO_O)
      ^ ($past(GPIO_OE_O) & $past(WDATA_I[NUM_PINS-1:0])))) else $error("toggle");
  a_level_read:
    assert property (RD_I && ADDR_I == 8'h04 |=> RDATA_O[NUM_PINS-1:0] == $past(GPIO_O)) else $error("readback");
  a_rd_idle:
    assert property (!RD_I |=> RDATA_O == 32'h0000_0000) else $error("idle data");
  a_occ_state:
    assert property (s_calm |-> OCCUPIED_O == (OCC_I == pol_q)) else $error("occupancy");
  a_ivl_span:
    assert property (s_ivl |=> s_ivl_hold) else $error("interval");
endmodule // gpio_occ_props
bind gpio_occ_port gpio_occ_props #(
  .NUM_PINS (NUM_PINS)
) i_props (
  .CLK_SYS_I  (CLK_SYS_I),
  .RST_N_I    (RST_N_I),
  .WR_I       (WR_I),
  .RD_I       (RD_I),
  .OCC_I      (OCC_I),
  .OCCUPIED_O (OCCUPIED_O),
  .ADDR_I     (ADDR_I),
  .WDATA_I    (WDATA_I),
  .RDATA_O    (RDATA_O),
  .GPIO_O     (GPIO_O),
  .GPIO_OE_O  (GPIO_OE_O)
);
`default_nettype wire

// ---- test/pin_side_model.sv ----
// far side: external equipment on the pins and the occupancy sensor
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
  input  wire logic [3:0] gpio_o,
  input  wire logic [3:0] oe,
  input  wire logic [3:0] ext,
  input  wire logic       lvl,
  output logic      [3:0] gpio_i,
  output logic            occ
);
  // device wins where it drives, equipment elsewhere
  assign gpio_i = oe & gpio_o | ~oe & ext;
  assign occ = lvl;
endmodule // pin_side_model
`default_nettype wire
